//--- rtl/tcc_regs.svh
// Register indices, field positions and reset values of the timer core
`ifndef TCC_REGS_SVH
`define TCC_REGS_SVH

// Register indices; the byte address is four times the index
`define TCC_IDX_CTRL 6'h0E
`define TCC_IDX_CNTH 6'h0F
`define TCC_IDX_CNTL 6'h10
`define TCC_IDX_MODH 6'h11
`define TCC_IDX_MODL 6'h12

// Control and status fields
`define TCC_BIT_OVF 7
`define TCC_BIT_OIE 6
`define TCC_BIT_HALT 5
`define TCC_BIT_CLR 4
`define TCC_PS_HI 2
`define TCC_PS_LO 0

// Reset values
`define TCC_RST_PS 3'h0
`define TCC_RST_HALT 1'h1
`define TCC_RST_MOD 8'hFF
`define TCC_RST_CNT 16'h0000

// Prescaler width, enough for the divide-by-64 step
`define TCC_PRE_W 6

`endif

//--- rtl/tcc_pkg.sv
// Types shared by the timer counter core
package tcc_pkg;

  typedef logic [15:0] tcc_count_t;
  typedef logic [7:0] tcc_byte_t;

  typedef enum logic [2:0] {
    tcc_div1 = 3'h0,
    tcc_div2 = 3'h1,
    tcc_div4 = 3'h2,
    tcc_div8 = 3'h3,
    tcc_div16 = 3'h4,
    tcc_div32 = 3'h5,
    tcc_div64 = 3'h6,
    tcc_ext = 3'h7
  } tcc_clk_sel_e;

endpackage

//--- rtl/tcc_core.sv
// Sixteen-bit timer counter core with prescaler, modulo and APB registers
//
// What this block does
// [RQ1] Divider select 111 clocks the counter from the external timer pin.
// [RQ2] Codes 000-110 divide the bus clock by 1..64; reset selects 000.
// [RQ3] The external clock stays at most 4 MHz and half the bus clock.
// [RQ4] With the external clock selected the pin is forced to an input.
// [RQ5] Counter reads as high and low byte, read-only, zero after reset.
// [RQ6] High-byte read latches the low byte until the low byte is read.
// [RQ7] After a high-byte read in break, software reads the low byte too.
// [RQ8] At the modulo value the flag sets; next tick restarts from zero.
// [RQ9] Modulo high write suppresses flag and interrupt until low write.
// [RQ10] Modulo bytes are read/write and reset to all ones.
// [RQ11] Software clears the counter before writing a new modulo value.
// [RQ12] Flag clears by read-while-set then write zero; new overflow wins.
// [RQ13] Writing one to the flag does nothing; reset clears it.
// [RQ14] Interrupt enable raises a request while the flag is set.
// [RQ15] Halt bit freezes the counter; reset sets it.
// [RQ16] Halt blocks input captures on capture channels.
// [RQ17] Software keeps halt clear in wait mode if wake-up is needed.
// [RQ18] Clear bit zeroes counter and prescaler; self-clears, reads zero.
// [RQ19] Halt and clear written together stop the counter at zero.
// [RQ20] Debug break stops the counter and suppresses captures.
// [RQ21] Unhalted and out of break, the counter steps once per selected clock pulse.
`timescale 1ns/10ps
`include "tcc_regs.svh"

module tcc_core
  import tcc_pkg::*;
(
  input wire logic pclk, // Bus clock, 40 MHz
  input wire logic presetn, // Asynchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction, high for write
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic ext_timer_clock_pin, // External clock pin, async
  input wire logic break_state, // Debug break, same clock domain
  output logic ext_pin_force_input, // Pin held as input
  output logic overflow_irq, // Overflow interrupt request
  output logic overflow_pulse, // One-cycle overflow event
  output tcc_count_t counter_value, // Counter value for channels
  output logic counter_halt_out, // Halt state for channels
  output logic capture_block // Input captures inhibited
);

  // ==========================================================
  // Register state
  // ==========================================================
  logic overflow_flag;
  logic overflow_irq_enable;
  logic counter_halt;
  tcc_clk_sel_e clock_divider_select;
  tcc_byte_t modulo_hi;
  tcc_byte_t modulo_lo;
  logic modulo_pending;
  tcc_count_t count;
  tcc_byte_t low_hold;
  logic low_held;
  logic clear_armed;
  logic [`TCC_PRE_W-1:0] prescale;

  // ==========================================================
  // Bus decode
  // ==========================================================
  logic setup_phase;
  logic write_done;
  logic word_ok;
  logic hit_ctrl;
  logic hit_cnth;
  logic hit_cntl;
  logic hit_modh;
  logic hit_modl;
  logic mapped;

  assign setup_phase = psel && !penable;
  assign write_done = psel && penable && pready && pwrite;
  assign word_ok = (paddr[1:0] == 2'h0);
  assign hit_ctrl = word_ok && (paddr[7:2] == `TCC_IDX_CTRL);
  assign hit_cnth = word_ok && (paddr[7:2] == `TCC_IDX_CNTH);
  assign hit_cntl = word_ok && (paddr[7:2] == `TCC_IDX_CNTL);
  assign hit_modh = word_ok && (paddr[7:2] == `TCC_IDX_MODH);
  assign hit_modl = word_ok && (paddr[7:2] == `TCC_IDX_MODL);
  assign mapped = hit_ctrl || hit_cnth || hit_cntl || hit_modh || hit_modl;

  // Reads take their side effects at the setup edge, where the data is
  // sampled, so the latched low byte matches the high byte returned.
  logic rd_ctrl;
  logic rd_cnth;
  logic rd_cntl;

  assign rd_ctrl = setup_phase && !pwrite && hit_ctrl;
  assign rd_cnth = setup_phase && !pwrite && hit_cnth;
  assign rd_cntl = setup_phase && !pwrite && hit_cntl;

  logic wr_ctrl;
  logic wr_modh;
  logic wr_modl;
  logic clear_req;

  assign wr_ctrl = write_done && hit_ctrl;
  assign wr_modh = write_done && hit_modh;
  assign wr_modl = write_done && hit_modl;
  // [RQ18] Counter clear request
  assign clear_req = wr_ctrl && pwdata[`TCC_BIT_CLR];

  // ==========================================================
  // External clock pin synchroniser and edge detect
  // ==========================================================
  logic ext_meta;
  logic ext_sync;
  logic ext_last;
  logic ext_rise;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
      ext_last <= 1'b0;
    end else begin
      ext_meta <= ext_timer_clock_pin;
      ext_sync <= ext_meta;
      ext_last <= ext_sync;
    end
  end

  assign ext_rise = ext_sync && !ext_last;

  // ==========================================================
  // Prescaler and timer clock select
  // ==========================================================
  logic running;
  logic [`TCC_PRE_W-1:0] pre_mask;
  logic tick;

  // [RQ15] Halt and break freeze the count
  assign running = !counter_halt && !break_state;

  always_comb begin
    case (clock_divider_select)
      tcc_div1: pre_mask = 6'h00;
      tcc_div2: pre_mask = 6'h01;
      tcc_div4: pre_mask = 6'h03;
      tcc_div8: pre_mask = 6'h07;
      tcc_div16: pre_mask = 6'h0F;
      tcc_div32: pre_mask = 6'h1F;
      tcc_div64: pre_mask = 6'h3F;
      default: pre_mask = 6'h00;
    endcase
  end

  always_comb begin
    tick = 1'b0;
    if (running) begin
      // [RQ1] External pin as timer clock
      if (clock_divider_select == tcc_ext) begin
        tick = ext_rise;
      end else begin
        // [RQ2] Bus clock divided by prescaler
        tick = ((prescale & pre_mask) == pre_mask);
      end
    end
  end

  // [RQ21] Prescaler runs from the bus clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale <= '0;
    end else if (clear_req) begin
      prescale <= '0;
    end else if (running) begin
      prescale <= prescale + 1'b1;
    end
  end

  // ==========================================================
  // Counter and overflow event
  // ==========================================================
  tcc_count_t modulo;
  tcc_count_t next_count;
  logic ovf_event;

  assign modulo = {modulo_hi, modulo_lo};

  always_comb begin
    next_count = count;
    if (tick) begin
      // [RQ8] Restart from zero after the modulo value
      if (count == modulo) begin
        next_count = 16'h0000;
      end else begin
        next_count = count + 16'h0001;
      end
    end
  end

  // [RQ9] Overflow suppressed while modulo write is pending
  assign ovf_event = tick && (next_count == modulo) && !modulo_pending;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= `TCC_RST_CNT;
    end else if (clear_req) begin
      // [RQ19] Clear wins; with halt set the count stays zero
      count <= 16'h0000;
    end else begin
      // [RQ21] One step per timer clock
      count <= next_count;
    end
  end

  // ==========================================================
  // Control and status register
  // ==========================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_irq_enable <= 1'b0;
      counter_halt <= `TCC_RST_HALT;
      clock_divider_select <= tcc_clk_sel_e'(`TCC_RST_PS);
    end else if (wr_ctrl) begin
      // [RQ14] Enable bit
      overflow_irq_enable <= pwdata[`TCC_BIT_OIE];
      // [RQ15] Halt bit
      counter_halt <= pwdata[`TCC_BIT_HALT];
      clock_divider_select <=
        tcc_clk_sel_e'(pwdata[`TCC_PS_HI:`TCC_PS_LO]);
    end
  end

  // Two-step clear: armed by a read that sees the flag set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clear_armed <= 1'b0;
    end else if (ovf_event || wr_ctrl) begin
      // [RQ12] A new overflow or any control register write disarms
      clear_armed <= 1'b0;
    end else if (rd_ctrl && overflow_flag) begin
      clear_armed <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_flag <= 1'b0;
    end else if (ovf_event) begin
      // [RQ8] Set wins over a clear in the same cycle
      overflow_flag <= 1'b1;
    end else if (wr_ctrl && clear_armed && !pwdata[`TCC_BIT_OVF]) begin
      // [RQ12] Zero write after armed read clears
      overflow_flag <= 1'b0;
    end
    // [RQ13] Writing one leaves the flag as it is
  end

  // ==========================================================
  // Modulo registers
  // ==========================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      modulo_hi <= `TCC_RST_MOD;
      modulo_lo <= `TCC_RST_MOD;
    end else begin
      // [RQ10] Both modulo bytes writable
      if (wr_modh) begin
        modulo_hi <= pwdata[7:0];
      end
      if (wr_modl) begin
        modulo_lo <= pwdata[7:0];
      end
    end
  end

  // [RQ9] High write opens a window closed by the low write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      modulo_pending <= 1'b0;
    end else if (wr_modl) begin
      modulo_pending <= 1'b0;
    end else if (wr_modh) begin
      modulo_pending <= 1'b1;
    end
  end

  // ==========================================================
  // Counter low-byte latch
  // ==========================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_hold <= 8'h00;
      low_held <= 1'b0;
    end else if (rd_cntl) begin
      // [RQ6] Low-byte read releases the latch
      low_held <= 1'b0;
    end else if (rd_cnth && !low_held) begin
      // [RQ6] First high-byte read captures the low byte
      low_hold <= count[7:0];
      low_held <= 1'b1;
    end
  end

  // ==========================================================
  // Read data mux
  // ==========================================================
  tcc_byte_t ctrl_view;
  tcc_byte_t rd_byte;

  // [RQ18] Clear bit and reserved bit read as zero
  assign ctrl_view = {overflow_flag, overflow_irq_enable, counter_halt,
                      2'b00, clock_divider_select};

  always_comb begin
    rd_byte = 8'h00;
    if (hit_ctrl) begin
      rd_byte = ctrl_view;
    end else if (hit_cnth) begin
      // [RQ5] Counter high byte
      rd_byte = count[15:8];
    end else if (hit_cntl) begin
      // [RQ7] Held value returned until released
      rd_byte = low_held ? low_hold : count[7:0];
    end else if (hit_modh) begin
      rd_byte = modulo_hi;
    end else if (hit_modl) begin
      rd_byte = modulo_lo;
    end
  end

  // ==========================================================
  // APB answer: one wait-free access phase
  // ==========================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (setup_phase) begin
      pready <= 1'b1;
      pslverr <= !mapped;
      prdata <= pwrite ? 32'h0000_0000 : {24'h000000, rd_byte};
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // ==========================================================
  // Outputs to pins and channels
  // ==========================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_pin_force_input <= 1'b0;
      overflow_irq <= 1'b0;
      overflow_pulse <= 1'b0;
      counter_value <= `TCC_RST_CNT;
      counter_halt_out <= `TCC_RST_HALT;
      capture_block <= 1'b1;
    end else begin
      // [RQ4] Pin forced to input under external clock
      ext_pin_force_input <= (clock_divider_select == tcc_ext);
      // [RQ14] Request follows enabled flag
      overflow_irq <= overflow_irq_enable && overflow_flag &&
                      !(modulo_pending && !ovf_event);
      overflow_pulse <= ovf_event;
      counter_value <= count;
      counter_halt_out <= counter_halt;
      // [RQ16] [RQ20] Captures blocked by halt or break
      capture_block <= counter_halt || break_state;
    end
  end

endmodule

//--- tb/tcc_core_asserts.sv
// Port-level assertions for the timer counter core
`timescale 1ns/10ps
module tcc_core_asserts
  import tcc_pkg::*;
(
  input wire logic pclk, // Bus clock
  input wire logic presetn, // Reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic [7:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [31:0] prdata, // APB read data
  input wire logic pready, // APB ready
  input wire logic pslverr, // APB error
  input wire logic ext_timer_clock_pin, // External clock
  input wire logic break_state, // Debug break
  input wire logic ext_pin_force_input, // Pin forced input
  input wire logic overflow_irq, // Overflow request
  input wire logic overflow_pulse, // Overflow event
  input wire tcc_count_t counter_value, // Counter copy
  input wire logic counter_halt_out, // Halt copy
  input wire logic capture_block // Captures inhibited
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================
  // Sequences
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_held;
    counter_halt_out ##1 counter_halt_out;
  endsequence
  sequence s_brk;
    break_state ##1 break_state;
  endsequence
  // ==========================================
  // Properties
  a_ready_one_cycle: assert property (s_setup |=> pready ##1 !pready)
    else $error("pready not a single cycle after setup");
  a_slverr_unmapped: assert property (psel && !penable &&
    (paddr[1:0] != 2'h0 || paddr < 8'h38 || paddr > 8'h48)
    |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_clear_reads_zero: assert property (
    s_setup and !pwrite && paddr == 8'h38 |=> !prdata[4])
    else $error("clear bit read back as one");
  a_halt_freezes: assert property (
    s_held |-> $stable(counter_value) || counter_value == 16'h0)
    else $error("counter moved while halted");
  a_break_freezes: assert property (
    s_brk |=> $stable(counter_value) || counter_value == 16'h0)
    else $error("counter moved during break");
  a_halt_blocks: assert property (counter_halt_out |-> capture_block)
    else $error("captures not blocked while halted");
  a_break_blocks: assert property (
    $past(break_state) |-> capture_block)
    else $error("captures not blocked in break");
  a_pulse_single: assert property (overflow_pulse |=> !overflow_pulse)
    else $error("overflow pulse longer than one cycle");
  a_irq_cause: assert property ($rose(overflow_irq) |->
    overflow_pulse || $past(overflow_pulse) ||
    $past(psel && penable && pwrite && pready, 2))
    else $error("interrupt rose without overflow or write");
  a_force_cause: assert property ($changed(ext_pin_force_input) |->
    $past(psel && penable && pwrite && pready) ||
    $past(psel && penable && pwrite && pready, 2))
    else $error("pin direction changed without a write");
endmodule

//--- tb/tcc_core_tb_top.sv
// Self-checking bench for the timer counter core
`timescale 1ns/10ps
`include "tcc_regs.svh"
module tcc_core_tb_top
  import tcc_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr, v;
  logic [31:0] pwdata, prdata, rd;
  logic ext_timer_clock_pin, break_state, ext_pin_force_input;
  logic overflow_irq, overflow_pulse, counter_halt_out, capture_block;
  tcc_count_t counter_value, cnt;
  int mismatches, comparisons;
  tcc_core i_tcc_core (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .ext_timer_clock_pin(ext_timer_clock_pin), .break_state(break_state),
    .ext_pin_force_input(ext_pin_force_input), .overflow_irq(overflow_irq),
    .overflow_pulse(overflow_pulse), .counter_value(counter_value),
    .counter_halt_out(counter_halt_out), .capture_block(capture_block)
  );
  initial begin
    pclk = 1'h0;
    forever #12.5 pclk = ~pclk;
  end
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // ==========================================
  // APB master
  task automatic apb(input logic w, input logic [5:0] idx,
                     input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {idx, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'h1;
    // Waits for the answer; only the watchdog ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    apb(1'h1, idx, d);
  endtask
  task automatic rdc(input logic [5:0] idx, input logic [31:0] exp);
    apb(1'h0, idx, 8'h0);
    chk(rd, exp);
  endtask
  task automatic wait_ovf();
    int n;
    n = 0;
    while (overflow_pulse !== 1'h1 && n < 200) begin
      @(posedge pclk);
      n++;
    end
    chk({31'h0, overflow_pulse}, 32'h1);
  endtask
  // ==========================================
  // Scenarios
  task automatic t_reset();
    rdc(`TCC_IDX_CTRL, 32'h20);
    rdc(`TCC_IDX_CNTH, 32'h0);
    rdc(`TCC_IDX_CNTL, 32'h0);
    rdc(`TCC_IDX_MODH, 32'hFF);
    rdc(`TCC_IDX_MODL, 32'hFF);
    chk({31'h0, capture_block}, 32'h1);
    apb(1'h0, 6'h20, 8'h0);
    chk({31'h0, er}, 32'h1);
    wr(`TCC_IDX_CNTH, 8'h55);
    rdc(`TCC_IDX_CNTH, 32'h0);
    rdc(`TCC_IDX_CNTL, 32'h0);
    $display("reset test done");
  endtask
  task automatic t_ovf();
    wr(`TCC_IDX_MODL, 8'h05);
    wr(`TCC_IDX_MODH, 8'h00);
    wr(`TCC_IDX_CTRL, 8'h40);
    repeat (40) @(posedge pclk);
    rdc(`TCC_IDX_CTRL, 32'h40);
    chk({31'h0, overflow_irq}, 32'h0);
    wr(`TCC_IDX_MODL, 8'h05);
    rdc(`TCC_IDX_MODL, 32'h05);
    wr(`TCC_IDX_CTRL, 8'h50);
    wait_ovf();
    rdc(`TCC_IDX_CTRL, 32'hC0);
    chk({31'h0, overflow_irq}, 32'h1);
    wr(`TCC_IDX_CTRL, 8'hE0);
    wr(`TCC_IDX_CTRL, 8'h60);
    rdc(`TCC_IDX_CTRL, 32'hE0);
    apb(1'h0, `TCC_IDX_CNTL, 8'h0);
    v = rd[7:0];
    wr(`TCC_IDX_CTRL, 8'h60);
    rdc(`TCC_IDX_CTRL, 32'h60);
    rdc(`TCC_IDX_CNTL, {24'h0, v});
    chk({31'h0, overflow_irq}, 32'h0);
    wr(`TCC_IDX_CTRL, 8'h10);
    wait_ovf();
    rdc(`TCC_IDX_CTRL, 32'h80);
    wait_ovf();
    wr(`TCC_IDX_CTRL, 8'h20);
    rdc(`TCC_IDX_CTRL, 32'hA0);
    wr(`TCC_IDX_CTRL, 8'h20);
    rdc(`TCC_IDX_CTRL, 32'h20);
    $display("overflow test done");
  endtask
  task automatic t_latch();
    wr(`TCC_IDX_MODH, 8'hFF);
    wr(`TCC_IDX_MODL, 8'hFF);
    wr(`TCC_IDX_CTRL, 8'h30);
    repeat (10) @(posedge pclk);
    rdc(`TCC_IDX_CNTH, 32'h0);
    rdc(`TCC_IDX_CNTL, 32'h0);
    rdc(`TCC_IDX_CTRL, 32'h20);
    wr(`TCC_IDX_CTRL, 8'h00);
    apb(1'h0, `TCC_IDX_CNTH, 8'h0);
    apb(1'h0, `TCC_IDX_CNTH, 8'h0);
    apb(1'h0, `TCC_IDX_CNTL, 8'h0);
    v = rd[7:0];
    apb(1'h0, `TCC_IDX_CNTL, 8'h0);
    chk({31'h0, (rd[7:0] - v) > 8'h6}, 32'h1);
    $display("latch test done");
  endtask
  task automatic t_div();
    tcc_count_t exp;
    for (int s = 0; s < 7; s++) begin
      wr(`TCC_IDX_CTRL, {5'h06, s[2:0]});
      wr(`TCC_IDX_CTRL, {5'h00, s[2:0]});
      repeat (253) @(posedge pclk);
      wr(`TCC_IDX_CTRL, {5'h04, s[2:0]});
      apb(1'h0, `TCC_IDX_CNTH, 8'h0);
      cnt[15:8] = rd[7:0];
      apb(1'h0, `TCC_IDX_CNTL, 8'h0);
      cnt[7:0] = rd[7:0];
      exp = 16'h0100 >> s;
      chk({31'h0, cnt + 16'h1 >= exp && cnt <= exp + 16'h1}, 32'h1);
    end
    $display("divider test done");
  endtask
  task automatic t_ext();
    wr(`TCC_IDX_CTRL, 8'h37);
    repeat (3) @(posedge pclk);
    chk({31'h0, ext_pin_force_input}, 32'h1);
    wr(`TCC_IDX_CTRL, 8'h07);
    repeat (10) begin
      repeat (5) @(posedge pclk);
      ext_timer_clock_pin <= 1'h1;
      repeat (5) @(posedge pclk);
      ext_timer_clock_pin <= 1'h0;
    end
    repeat (8) @(posedge pclk);
    wr(`TCC_IDX_CTRL, 8'h27);
    rdc(`TCC_IDX_CNTL, 32'h0A);
    chk({16'h0, counter_value}, 32'h0A);
    chk({31'h0, counter_halt_out}, 32'h1);
    wr(`TCC_IDX_CTRL, 8'h20);
    repeat (3) @(posedge pclk);
    chk({31'h0, ext_pin_force_input}, 32'h0);
    $display("external clock test done");
  endtask
  task automatic t_brk();
    wr(`TCC_IDX_CTRL, 8'h30);
    wr(`TCC_IDX_CTRL, 8'h00);
    repeat (3) @(posedge pclk);
    chk({31'h0, capture_block}, 32'h0);
    chk({31'h0, counter_halt_out}, 32'h0);
    break_state <= 1'h1;
    repeat (3) @(posedge pclk);
    chk({31'h0, capture_block}, 32'h1);
    apb(1'h0, `TCC_IDX_CNTL, 8'h0);
    v = rd[7:0];
    repeat (10) @(posedge pclk);
    rdc(`TCC_IDX_CNTL, {24'h0, v});
    apb(1'h0, `TCC_IDX_CNTH, 8'h0);
    break_state <= 1'h0;
    repeat (10) @(posedge pclk);
    rdc(`TCC_IDX_CNTL, {24'h0, v});
    wr(`TCC_IDX_CTRL, 8'h20);
    $display("break test done");
  endtask
  initial begin
    {presetn, psel, penable, pwrite, ext_timer_clock_pin} = 5'h00;
    {paddr, pwdata, break_state} = 41'h0;
    mismatches = 0;
    comparisons = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'h1;
    t_reset();
    t_ovf();
    t_latch();
    t_div();
    t_ext();
    t_brk();
    summarize();
  end
  initial begin
    repeat (40000) @(posedge pclk);
    chk(32'h0, 32'h1);
    summarize();
  end
endmodule
bind tcc_core tcc_core_asserts i_tcc_core_asserts (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr),
  .ext_timer_clock_pin(ext_timer_clock_pin), .break_state(break_state),
  .ext_pin_force_input(ext_pin_force_input), .overflow_irq(overflow_irq),
  .overflow_pulse(overflow_pulse), .counter_value(counter_value),
  .counter_halt_out(counter_halt_out), .capture_block(capture_block)
);
